// >>> src/serial_channel_module_glue.sv
// Glue logic around two serial channel kernels: clock gating, receive pin choice,
// receive buffer packing, service request control and the APB register map.
// Assumes kernel signals are synchronous to pclk and request lines last two cycles.
`timescale 1ns/100ps
`default_nettype none

module serial_channel_module_glue (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] ext_disable_req,
	input wire logic debug_suspend_req,
	input wire logic [1:0] rx_pin_a,
	input wire logic [1:0] rx_pin_b,
	output logic [1:0] kernel_rx_in,
	output logic [1:0] module_clock_en,
	output logic [15:0] run_clock_divider,
	input wire logic [1:0] rx_frame_valid,
	input wire logic [17:0] rx_frame_data,
	input wire logic [1:0] rx_parity_bit,
	output logic [5:0] frame_mode_select,
	input wire logic [7:0] kernel_request_lines,
	output logic [7:0] request_flags,
	output logic irq
);
	logic [31:0] clock_gate_reg [2];
	logic [31:0] clock_gate_next [2];
	logic [1:0] pin_select_reg;
	logic [1:0] pin_select_next;
	logic [2:0] mode_reg [2];
	logic [2:0] mode_next [2];
	logic [8:0] rx_buf_reg [2];
	logic [8:0] rx_buf_next [2];
	logic [15:0] src_reg [8];
	logic [15:0] src_next [8];
	logic [7:0] line_dly_reg;
	logic [7:0] line_rise;
	logic [7:0] irq_mask_reg;
	logic [7:0] irq_mask_next;
	logic wr_acc;
	logic rd_ok;
	logic mod_sel;
	logic [7:0] ofs;
	logic in_window;
	logic [31:0] rd_mux;
	logic [1:0] gate_armed_reg;
	logic [1:0] gate_armed_next;

	// Packs a received frame; parity position depends on frame mode
	function automatic logic [8:0] pack_rx(input logic [2:0] mode, input logic [8:0] data,
		input logic parity);
		logic [8:0] v;
		v = data;
		if (mode == serial_glue_pkg::MODE_7_PARITY) begin
			v[serial_glue_pkg::PAR_BIT_7] = parity;
			v[8] = 1'b0;
		end else if (mode == serial_glue_pkg::MODE_8_PARITY) begin
			v[serial_glue_pkg::PAR_BIT_8] = parity;
		end
		return v;
	endfunction

	// Selects which request control a local offset addresses
	function automatic logic [2:0] src_index(input logic [7:0] o);
		logic [2:0] r;
		r = 3'h4;
		unique case (o)
			serial_glue_pkg::OFS_TX_DONE_SRC: r = 3'h0;
			serial_glue_pkg::OFS_RX_SRC: r = 3'h1;
			serial_glue_pkg::OFS_ERROR_SRC: r = 3'h2;
			serial_glue_pkg::OFS_TX_BUF_SRC: r = 3'h3;
			default: r = 3'h4;
		endcase
		return r;
	endfunction

	// Zero-wait APB; decode of both module windows
	assign pready = 1'b1;
	assign mod_sel = paddr[8];
	assign ofs = paddr[7:0];
	assign in_window = (paddr[11:9] == serial_glue_pkg::MOD0_BASE[11:9]);
	assign rd_ok = in_window && (paddr[1:0] == 2'h0) && (ofs == serial_glue_pkg::OFS_CLOCK_GATE
		|| ofs == serial_glue_pkg::OFS_PIN_SELECT || ofs == serial_glue_pkg::OFS_FRAME_MODE
		|| ofs == serial_glue_pkg::OFS_RX_BUFFER || ofs == serial_glue_pkg::OFS_IRQ_STATUS
		|| ofs == serial_glue_pkg::OFS_IRQ_MASK || src_index(ofs) != 3'h4);
	assign pslverr = psel && penable && !rd_ok;
	assign wr_acc = clk_en && psel && penable && pwrite && rd_ok;
	// Edge, not level: a two-cycle pulse sets its flag once
	assign line_rise = kernel_request_lines & ~line_dly_reg;

	always_comb begin
		int m;
		int s;
		int k;
		logic [31:0] cg;
		m = 0;
		s = 0;
		k = 0;
		cg = 32'h0000_0000;
		for (m = 0; m < serial_glue_pkg::NUM_MOD; m++) begin
			cg = clock_gate_reg[m];
			gate_armed_next[m] = gate_armed_reg[m];
			pin_select_next[m] = pin_select_reg[m];
			mode_next[m] = mode_reg[m];
			rx_buf_next[m] = rx_buf_reg[m];
			if (rx_frame_valid[m]) begin
				rx_buf_next[m] = pack_rx(mode_reg[m], rx_frame_data[9*m +: 9], rx_parity_bit[m]);
			end
			if (wr_acc && mod_sel == m[0]) begin
				if (ofs == serial_glue_pkg::OFS_CLOCK_GATE) begin
					gate_armed_next[m] = 1'b1;
					cg[serial_glue_pkg::CG_DISABLE_REQ] = pwdata[0];
					cg[serial_glue_pkg::CG_EXT_BLOCK] = pwdata[3];
					cg[15:8] = pwdata[15:8];
					if (pwdata[serial_glue_pkg::CG_SUSPEND_WE]) begin
						cg[serial_glue_pkg::CG_SUSPEND_EN] = pwdata[2];
						cg[serial_glue_pkg::CG_FAST_OFF] = pwdata[5];
					end
				end
				if (ofs == serial_glue_pkg::OFS_PIN_SELECT) begin
					pin_select_next[m] = pwdata[0];
				end
				if (ofs == serial_glue_pkg::OFS_FRAME_MODE) begin
					mode_next[m] = pwdata[2:0];
				end
			end
			// Disabled until the first control write, by request, external request or suspend
			cg[serial_glue_pkg::CG_DISABLE_STAT] = !gate_armed_next[m] || cg[0]
				|| (ext_disable_req[m] && !cg[serial_glue_pkg::CG_EXT_BLOCK])
				|| (debug_suspend_req && cg[serial_glue_pkg::CG_SUSPEND_EN]
					&& cg[serial_glue_pkg::CG_FAST_OFF]);
			cg[31:16] = 16'h0000;
			cg[7:6] = 2'h0;
			cg[4] = 1'b0;
			clock_gate_next[m] = cg;
		end
		for (s = 0; s < 8; s++) begin
			src_next[s] = src_reg[s];
			k = s / serial_glue_pkg::NUM_SRC;
			if (wr_acc && mod_sel == k[0] && src_index(ofs) == 3'(s % serial_glue_pkg::NUM_SRC)) begin
				src_next[s][7:0] = pwdata[7:0];
				src_next[s][11:10] = pwdata[11:10];
				src_next[s][serial_glue_pkg::SR_ENABLE] = pwdata[12];
				if (pwdata[serial_glue_pkg::SR_CLEAR]) begin
					src_next[s][serial_glue_pkg::SR_FLAG] = 1'b0;
				end
			end
			// Hardware set and the set bit win over a clear in the same cycle
			if (line_rise[s] || (wr_acc && mod_sel == k[0]
				&& src_index(ofs) == 3'(s % serial_glue_pkg::NUM_SRC)
				&& pwdata[serial_glue_pkg::SR_SET])) begin
				src_next[s][serial_glue_pkg::SR_FLAG] = 1'b1;
			end
			src_next[s][15:14] = 2'h0;
			src_next[s][9:8] = 2'h0;
		end
		irq_mask_next = irq_mask_reg;
		if (wr_acc && ofs == serial_glue_pkg::OFS_IRQ_MASK) begin
			irq_mask_next[4*mod_sel +: 4] = pwdata[3:0];
		end
		if (wr_acc && ofs == serial_glue_pkg::OFS_IRQ_STATUS) begin
			// Write one to clear, unless a new event arrives now
			for (s = 0; s < 4; s++) begin
				k = 4 * mod_sel + s;
				if (pwdata[s] && !line_rise[k]) begin
					src_next[k][serial_glue_pkg::SR_FLAG] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				clock_gate_reg[i] <= serial_glue_pkg::CG_RESET;
				mode_reg[i] <= 3'h0;
				rx_buf_reg[i] <= 9'h000;
			end
			for (int i = 0; i < 8; i++) begin
				src_reg[i] <= 16'h0000;
			end
			pin_select_reg <= 2'h0;
			gate_armed_reg <= 2'h0;
			line_dly_reg <= 8'h00;
			irq_mask_reg <= 8'h00;
		end else if (clk_en) begin
			for (int i = 0; i < 2; i++) begin
				clock_gate_reg[i] <= clock_gate_next[i];
				mode_reg[i] <= mode_next[i];
				rx_buf_reg[i] <= rx_buf_next[i];
			end
			for (int i = 0; i < 8; i++) begin
				src_reg[i] <= src_next[i];
			end
			pin_select_reg <= pin_select_next;
			gate_armed_reg <= gate_armed_next;
			line_dly_reg <= kernel_request_lines;
			irq_mask_reg <= irq_mask_next;
		end
	end

	// Read mux
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (ofs)
			serial_glue_pkg::OFS_CLOCK_GATE: rd_mux = clock_gate_reg[mod_sel];
			serial_glue_pkg::OFS_PIN_SELECT: rd_mux = {31'h0, pin_select_reg[mod_sel]};
			serial_glue_pkg::OFS_FRAME_MODE: rd_mux = {29'h0, mode_reg[mod_sel]};
			serial_glue_pkg::OFS_RX_BUFFER: rd_mux = {23'h0, rx_buf_reg[mod_sel]};
			serial_glue_pkg::OFS_IRQ_MASK: rd_mux = {28'h0, irq_mask_reg[4*mod_sel +: 4]};
			serial_glue_pkg::OFS_IRQ_STATUS: rd_mux = {28'h0, request_flags[4*mod_sel +: 4]};
			default: rd_mux = {16'h0, src_reg[{mod_sel, 2'(src_index(ofs))}]};
		endcase
	end
	assign prdata = (psel && !pwrite && rd_ok) ? rd_mux : 32'h0000_0000;

	always_comb begin
		for (int m = 0; m < 2; m++) begin
			// Pin direction stays with the port logic and software
			kernel_rx_in[m] = pin_select_reg[m] ? rx_pin_b[m] : rx_pin_a[m];
			module_clock_en[m] = !clock_gate_reg[m][serial_glue_pkg::CG_DISABLE_STAT];
			run_clock_divider[8*m +: 8] = clock_gate_reg[m][15:8];
			frame_mode_select[3*m +: 3] = mode_reg[m];
		end
		for (int s = 0; s < 8; s++) begin
			request_flags[s] = src_reg[s][serial_glue_pkg::SR_FLAG];
		end
	end
	assign irq = |(request_flags & irq_mask_reg);

	property p_par7;
		@(posedge pclk) disable iff (!presetn)
		clk_en && rx_frame_valid[0] && mode_reg[0] == serial_glue_pkg::MODE_7_PARITY
			|=> rx_buf_reg[0][7] == $past(rx_parity_bit[0]);
	endproperty
	a_par7: assert property (p_par7) else $error("parity not in bit 7");
	property p_par8;
		@(posedge pclk) disable iff (!presetn)
		clk_en && rx_frame_valid[1] && mode_reg[1] == serial_glue_pkg::MODE_8_PARITY
			|=> rx_buf_reg[1][8] == $past(rx_parity_bit[1]);
	endproperty
	a_par8: assert property (p_par8) else $error("parity not in bit 8");
	property p_stat;
		@(posedge pclk) disable iff (!presetn)
		clock_gate_reg[0][0] |-> clock_gate_reg[0][1] && !module_clock_en[0];
	endproperty
	a_stat: assert property (p_stat) else $error("disable status wrong");
	property p_lock;
		@(posedge pclk) disable iff (!presetn)
		wr_acc && ofs == serial_glue_pkg::OFS_CLOCK_GATE && !mod_sel && !pwdata[4]
			|=> $stable(clock_gate_reg[0][2]) && $stable(clock_gate_reg[0][5]);
	endproperty
	a_lock: assert property (p_lock) else $error("protected field changed");
	property p_pin;
		@(posedge pclk) disable iff (!presetn)
		pin_select_reg[0] |-> kernel_rx_in[0] == rx_pin_b[0];
	endproperty
	a_pin: assert property (p_pin) else $error("wrong receive pin");
	property p_set;
		@(posedge pclk) disable iff (!presetn)
		clk_en && line_rise[2] |=> request_flags[2];
	endproperty
	a_set: assert property (p_set) else $error("flag not set by line");
	property p_resv;
		@(posedge pclk) disable iff (!presetn)
		psel && !pwrite && ofs == serial_glue_pkg::OFS_RX_BUFFER && rd_ok |-> prdata[31:9] == 23'h0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bits nonzero");
	property p_src;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |-> src_reg[5][15:14] == 2'h0 && src_reg[5][9:8] == 2'h0;
	endproperty
	a_src: assert property (p_src) else $error("reserved request bits set");
	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		irq_mask_reg[0] && request_flags[0] |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");
	property p_dis_rst;
		@(posedge pclk) disable iff (!presetn)
		!gate_armed_reg[0] |-> !module_clock_en[0];
	endproperty
	a_dis_rst: assert property (p_dis_rst) else $error("enabled before first write");
	property p_fast;
		@(posedge pclk) disable iff (!presetn)
		clk_en && !wr_acc && debug_suspend_req && clock_gate_reg[0][serial_glue_pkg::CG_SUSPEND_EN]
			&& clock_gate_reg[0][serial_glue_pkg::CG_FAST_OFF] |=> clock_gate_reg[0][1];
	endproperty
	a_fast: assert property (p_fast) else $error("suspend did not switch off");
	property p_div;
		@(posedge pclk) disable iff (!presetn)
		wr_acc && mod_sel && ofs == serial_glue_pkg::OFS_CLOCK_GATE
			|=> run_clock_divider[15:8] == $past(pwdata[15:8]);
	endproperty
	a_div: assert property (p_div) else $error("divider not written");
	property p_pin1;
		@(posedge pclk) disable iff (!presetn)
		!pin_select_reg[1] |-> kernel_rx_in[1] == rx_pin_a[1];
	endproperty
	a_pin1: assert property (p_pin1) else $error("wrong default receive pin");
	property p_swset;
		@(posedge pclk) disable iff (!presetn)
		wr_acc && !mod_sel && ofs == serial_glue_pkg::OFS_TX_DONE_SRC
			&& pwdata[serial_glue_pkg::SR_SET] |=> request_flags[0];
	endproperty
	a_swset: assert property (p_swset) else $error("set bit ignored");
	property p_swclr;
		@(posedge pclk) disable iff (!presetn)
		wr_acc && !mod_sel && ofs == serial_glue_pkg::OFS_TX_DONE_SRC
			&& pwdata[serial_glue_pkg::SR_CLEAR] && !pwdata[serial_glue_pkg::SR_SET]
			&& !line_rise[0] |=> !request_flags[0];
	endproperty
	a_swclr: assert property (p_swclr) else $error("clear bit ignored");
	property p_unmapped;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && !in_window |-> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	c_rx: cover property (@(posedge pclk) rx_frame_valid[0] && mode_reg[0] == 3'h3);
	c_en: cover property (@(posedge pclk) $fell(clock_gate_reg[1][1]));
	c_irq: cover property (@(posedge pclk) $rose(irq));
	c_w1c: cover property (@(posedge pclk) wr_acc && ofs == serial_glue_pkg::OFS_IRQ_STATUS);
endmodule
`default_nettype wire

// >>> src/serial_glue_pkg.sv
// Package: register map, field positions and reset values for the serial channel glue.
// Assumes an APB slave with 32-bit aligned registers and one module clock.
package serial_glue_pkg;
	// Module windows, 256 bytes each, selected by paddr[8]
	localparam logic [11:0] MOD0_BASE = 12'h800;
	localparam logic [11:0] MOD1_BASE = 12'h900;
	// Offsets inside a module window
	localparam logic [7:0] OFS_CLOCK_GATE = 8'h00;
	localparam logic [7:0] OFS_PIN_SELECT = 8'h04;
	localparam logic [7:0] OFS_FRAME_MODE = 8'h10;
	localparam logic [7:0] OFS_RX_BUFFER = 8'h24;
	localparam logic [7:0] OFS_TX_DONE_SRC = 8'hF0;
	localparam logic [7:0] OFS_RX_SRC = 8'hF4;
	localparam logic [7:0] OFS_ERROR_SRC = 8'hF8;
	localparam logic [7:0] OFS_TX_BUF_SRC = 8'hFC;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'hE0;
	localparam logic [7:0] OFS_IRQ_MASK = 8'hE4;
	// Clock gate control fields
	localparam int CG_DISABLE_REQ = 0;
	localparam int CG_DISABLE_STAT = 1;
	localparam int CG_SUSPEND_EN = 2;
	localparam int CG_EXT_BLOCK = 3;
	localparam int CG_SUSPEND_WE = 4;
	localparam int CG_FAST_OFF = 5;
	localparam int CG_DIV_LSB = 8;
	localparam logic [31:0] CG_RESET = 32'h0000_0002;
	// Service request fields
	localparam int SR_PRIO_LSB = 0;
	localparam int SR_TYPE_LSB = 10;
	localparam int SR_ENABLE = 12;
	localparam int SR_FLAG = 13;
	localparam int SR_CLEAR = 14;
	localparam int SR_SET = 15;
	localparam logic [31:0] SR_RESET = 32'h0000_0000;
	// Frame modes carrying a parity bit
	localparam logic [2:0] MODE_7_PARITY = 3'h3;
	localparam logic [2:0] MODE_8_PARITY = 3'h7;
	localparam int PAR_BIT_7 = 7;
	localparam int PAR_BIT_8 = 8;
	localparam int RX_WIDTH = 9;
	// Kernel request lines stay active this many clocks
	localparam int PULSE_CYCLES = 2;
	localparam int NUM_MOD = 2;
	localparam int NUM_SRC = 4;
endpackage

// >>> tb/kernel_model.sv
// Kernel stand-in: two-cycle request pulses and received frames.
// Assumes the bench calls its tasks right after a rising pclk edge.
`timescale 1ns/100ps
`default_nettype none
module kernel_model (
	input wire logic pclk,
	output logic [1:0] rx_frame_valid,
	output logic [17:0] rx_frame_data,
	output logic [1:0] rx_parity_bit,
	output logic [7:0] kernel_request_lines
);
	initial begin
		rx_frame_valid = 2'h0;
		rx_frame_data = 18'h0;
		rx_parity_bit = 2'h0;
		kernel_request_lines = 8'h00;
	end
	task automatic pulse(input int k);
		kernel_request_lines[k] <= 1'b1;
		repeat (2) @(posedge pclk);
		kernel_request_lines[k] <= 1'b0;
	endtask
	task automatic frame(input int m, input logic [8:0] d, input logic p);
		rx_frame_valid[m] <= 1'b1;
		rx_frame_data[9*m+:9] <= d;
		rx_parity_bit[m] <= p;
		@(posedge pclk);
		rx_frame_valid[m] <= 1'b0;
		// Flipped so a late capture shows up
		rx_frame_data[9*m+:9] <= ~d;
		rx_parity_bit[m] <= ~p;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Bench for the serial channel glue: APB master, kernel stand-in, checks.
// Assumes pready answers and registers update at the access edge.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, debug_suspend_req, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0] ext_disable_req, rx_pin_a, rx_pin_b, kernel_rx_in, module_clock_en;
	logic [1:0] rx_frame_valid, rx_parity_bit, touched;
	logic [15:0] run_clock_divider;
	logic [17:0] rx_frame_data;
	logic [5:0] frame_mode_select;
	logic [7:0] kernel_request_lines, request_flags;
	logic [31:0] cg[2];
	int n_fail, checked, cyc;
	serial_channel_module_glue dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_disable_req(ext_disable_req),
		.debug_suspend_req(debug_suspend_req), .rx_pin_a(rx_pin_a), .rx_pin_b(rx_pin_b),
		.kernel_rx_in(kernel_rx_in), .module_clock_en(module_clock_en),
		.run_clock_divider(run_clock_divider), .rx_frame_valid(rx_frame_valid),
		.rx_frame_data(rx_frame_data), .rx_parity_bit(rx_parity_bit),
		.frame_mode_select(frame_mode_select), .kernel_request_lines(kernel_request_lines),
		.request_flags(request_flags), .irq(irq));
	kernel_model kern (.pclk(pclk), .rx_frame_valid(rx_frame_valid),
		.rx_frame_data(rx_frame_data), .rx_parity_bit(rx_parity_bit),
		.kernel_request_lines(kernel_request_lines));
	function automatic logic [11:0] ad(input int m, input logic [7:0] o);
		return (m != 0 ? serial_glue_pkg::MOD1_BASE : serial_glue_pkg::MOD0_BASE) + {4'h0, o};
	endfunction
	// Status stays set after reset until software touches the register
	function automatic logic stat(input int m);
		if (!touched[m]) return 1'b1;
		return cg[m][0] | (ext_disable_req[m] & !cg[m][3]) | (debug_suspend_req & cg[m][2] & cg[m][5]);
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, r, x);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			finish_test;
		end
	end
	initial begin
		int m, j, k;
		logic [31:0] d, x;
		logic [11:0] a;
		logic [8:0] v;
		logic p;
		logic [31:0] cor[4] = '{32'h0000_0034, 32'h0000_0004, 32'hFFFF_FFFF, 32'h0000_0010};
		logic [11:0] bad[3] = '{12'h808, 12'h802, 12'h000};
		presetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ext_disable_req = 2'h0;
		debug_suspend_req = 1'b0;
		rx_pin_a = 2'h0;
		rx_pin_b = 2'h0;
		touched = 2'h0;
		cg[0] = 32'h0;
		cg[1] = 32'h0;
		d = $urandom(38);
		repeat (16) @(posedge pclk);
		chk("clock_en_reset", 32'(module_clock_en), 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		for (m = 0; m < 2; m++) begin
			rd(ad(m, serial_glue_pkg::OFS_CLOCK_GATE), serial_glue_pkg::CG_RESET, "gate_rst");
			rd(ad(m, serial_glue_pkg::OFS_PIN_SELECT), 32'h0, "pin_rst");
			for (j = 0; j < 4; j++)
				rd(ad(m, serial_glue_pkg::OFS_TX_DONE_SRC + 8'(4 * j)), 32'h0, "src_rst");
		end
		$display("test reset done");
		for (k = 0; k < 16; k++) begin
			m = k < 4 ? 0 : $urandom % 2;
			d = k < 4 ? cor[k] : $urandom;
			ext_disable_req <= 2'($urandom);
			debug_suspend_req <= 1'($urandom);
			apb(1'b1, ad(m, serial_glue_pkg::OFS_CLOCK_GATE), d);
			cg[m][0] = d[0];
			cg[m][3] = d[3];
			cg[m][15:8] = d[15:8];
			if (d[4]) begin
				cg[m][2] = d[2];
				cg[m][5] = d[5];
			end
			touched[m] = 1'b1;
			x = cg[m] | {30'h0, stat(m), 1'b0};
			rd(ad(m, 8'h00), x, "gate");
			chk("clock_en", 32'(module_clock_en[m]), 32'(!stat(m)));
			chk("divider", 32'(run_clock_divider[8*m+:8]), 32'(cg[m][15:8]));
		end
		$display("test clock gate done");
		for (k = 0; k < 6; k++) begin
			m = k % 2;
			d = $urandom;
			// Pins only driven in, direction belongs to the port side
			rx_pin_a <= 2'($urandom);
			rx_pin_b <= 2'($urandom);
			apb(1'b1, ad(m, serial_glue_pkg::OFS_PIN_SELECT), d);
			rd(ad(m, serial_glue_pkg::OFS_PIN_SELECT), {31'h0, d[0]}, "pin_sel");
			chk("rx_in", 32'(kernel_rx_in[m]), 32'(d[0] ? rx_pin_b[m] : rx_pin_a[m]));
		end
		$display("test pin select done");
		for (k = 0; k < 4; k++) begin
			m = k / 2;
			x = 32'(k % 2 ? serial_glue_pkg::MODE_8_PARITY : serial_glue_pkg::MODE_7_PARITY);
			apb(1'b1, ad(m, serial_glue_pkg::OFS_FRAME_MODE), x);
			chk("mode", 32'(frame_mode_select[3*m+:3]), x);
			v = 9'($urandom);
			p = 1'($urandom);
			kern.frame(m, v, p);
			x = k % 2 ? {23'h0, p, v[7:0]} : {23'h0, 1'b0, p, v[6:0]};
			rd(ad(m, serial_glue_pkg::OFS_RX_BUFFER), x, "rx_buf");
		end
		$display("test receive buffer done");
		for (k = 0; k < 8; k++) begin
			m = k / 4;
			j = k % 4;
			a = ad(m, serial_glue_pkg::OFS_TX_DONE_SRC + 8'(4 * j));
			d = $urandom & 32'hFFFF_3FFF;
			x = d & 32'h0000_1CFF;
			apb(1'b1, a, d);
			rd(a, x, "src_cfg");
			kern.pulse(k);
			@(negedge pclk);
			chk("flags", 32'(request_flags), 32'(1 << k));
			@(posedge pclk);
			rd(a, x | 32'h2000, "src_flag");
			apb(1'b1, ad(m, serial_glue_pkg::OFS_IRQ_MASK), 32'(1 << j));
			chk("irq_on", 32'(irq), 32'h1);
			apb(1'b1, ad(m, serial_glue_pkg::OFS_IRQ_MASK), 32'h0);
			chk("irq_off", 32'(irq), 32'h0);
			apb(1'b1, ad(m, serial_glue_pkg::OFS_IRQ_STATUS), 32'(1 << j));
			chk("w1c", 32'(request_flags), 32'h0);
			apb(1'b1, a, d | 32'h8000);
			rd(a, x | 32'h2000, "src_set");
			apb(1'b1, a, d | 32'h4000);
			rd(a, x, "src_clr");
		end
		$display("test service requests done");
		for (k = 0; k < 3; k++) begin
			apb(1'b0, bad[k], 32'h0);
			chk("slverr", 32'(e), 32'h1);
			chk("err_data", r, 32'h0);
		end
		clk_en <= 1'b0;
		apb(1'b1, ad(0, serial_glue_pkg::OFS_CLOCK_GATE), 32'h0000_FF00);
		clk_en <= 1'b1;
		rd(ad(0, 8'h00), cg[0] | {30'h0, stat(0), 1'b0}, "frozen");
		$display("test decode and freeze done");
		finish_test;
	end
endmodule
`default_nettype wire
